// >>> rtl/dpsgb_param_bank.sv
// How it works
// - Watchdog time 0 turns supervision off; 1 to 10000 is a timeout in ms.
// - Supervision arms at the first scan message once the watchdog is on.
// - After a guard timeout it waits unarmed for the next scan message.
// - Word order 0 sends and takes dwords high word first, 1 low first.
// - Stage temperature limit and warning read as signed 16-bit Celsius.
// - DC bus limits read back as unsigned 16-bit values in 100 mV steps.
// - The drive is switched off at or below the DC bus cutoff level.
// - A quick stop is raised at or below the DC bus quick-stop level.
// - Setting bit 0 of the save command copies persistent values to memory.
// - The save command reads zero once saving is done; the master polls it.
// - Factory restore 1 stores defaults in memory; 0 does nothing.
// - Factory restore acts only when written from the commissioning channel.
// - Restored defaults reach live values only after the next power-on.
// - User restore bit 0 resets persistent values but not comm settings.
// - A user restore never writes to nonvolatile memory.
// - Watchdog time is a read-write 16-bit value at parameter address 6414.
`timescale 1ns/100ps
module dpsgb_param_bank #(
  parameter int MS_CYCLES = dpsgb_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Parameter access port
  input wire logic param_req,
  input wire logic param_wr,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  input wire logic param_from_commissioning,
  output logic param_ack,
  output logic [15:0] param_rdata,
  // I/O scanning supervision
  input wire logic scan_msg,
  output logic guard_error,
  output logic scan_armed,
  // Dword word ordering on the link
  input wire logic [31:0] tx_dword,
  output logic [15:0] tx_word_first,
  output logic [15:0] tx_word_second,
  input wire logic [15:0] rx_word_first,
  input wire logic [15:0] rx_word_second,
  output logic [31:0] rx_dword,
  // DC bus supervision
  input wire logic [15:0] dc_bus_voltage,
  output logic drive_off,
  output logic quick_stop,
  // Persistent parameter control
  output logic user_restore_pulse,
  output logic nvm_req,
  input wire logic nvm_ack,
  output logic [15:0] nvm_word_order,
  output logic [15:0] nvm_scan_time
);
  import dpsgb_pkg::*;

  // ==========================================================
  // Shared helpers

  // Orders a dword as link words, first word in the upper half
  function automatic logic [31:0] order_words(input logic [31:0] value,
                                              input logic low_first);
    order_words = low_first ? {value[15:0], value[31:16]} : value;
  endfunction

  // ==========================================================
  // Registers
  logic [15:0] word_order_reg, word_order_next;
  logic [15:0] scan_wdog_reg, scan_wdog_next;
  logic ack_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] tx_first_reg, tx_second_reg;
  logic [31:0] rx_dword_reg;
  logic drive_off_reg, quick_stop_reg;
  logic user_pulse_reg;

  logic save_busy;
  logic factory_busy;

  // ==========================================================
  // Access decode
  wire wr_cycle = param_req && param_wr;
  wire rd_cycle = param_req && !param_wr;
  wire hit_save = (param_addr == ADDR_NV_SAVE);
  wire hit_factory = (param_addr == ADDR_FACTORY);
  wire hit_user = (param_addr == ADDR_USER_RESTORE);
  wire hit_order = (param_addr == ADDR_WORD_ORDER);
  wire hit_wdog = (param_addr == ADDR_SCAN_WDOG);
  wire hit_dc_upper = (param_addr == ADDR_DC_UPPER);
  wire hit_dc_cutoff = (param_addr == ADDR_DC_CUTOFF);
  wire hit_temp_warn = (param_addr == ADDR_TEMP_WARN);
  wire hit_temp_limit = (param_addr == ADDR_TEMP_LIMIT);
  wire hit_dc_qstop = (param_addr == ADDR_DC_QSTOP);

  // Write strobes with value checks; out-of-range writes are dropped
  wire wr_order_ok = wr_cycle && hit_order &&
                     (param_wdata <= WORD_ORDER_MAX);
  wire wr_wdog_ok = wr_cycle && hit_wdog &&
                    (param_wdata <= SCAN_WDOG_MAX);
  wire save_start = wr_cycle && hit_save &&
                    param_wdata[CMD_BIT];
  wire factory_start = wr_cycle && hit_factory &&
                       (param_wdata == FACTORY_YES) &&
                       param_from_commissioning;
  wire user_start = wr_cycle && hit_user &&
                    param_wdata[CMD_BIT];
  wire low_first = word_order_reg[ORDER_BIT];

  // ==========================================================
  // Next values of the writable parameters

  // Live values change only by direct writes; factory restore only
  // rewrites the stored image, so the running values stand until
  // power-on, and user restore leaves these communication values alone
  assign word_order_next = wr_order_ok ? param_wdata :
                           word_order_reg;
  assign scan_wdog_next = wr_wdog_ok ? param_wdata :
                          scan_wdog_reg;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rdata_next = 16'h0000;
    case (1'b1)
      hit_save: rdata_next = {15'h0000, save_busy};
      hit_factory: rdata_next = {15'h0000, factory_busy};
      hit_user: rdata_next = 16'h0000;
      hit_order: rdata_next = word_order_reg;
      hit_wdog: rdata_next = scan_wdog_reg;
      hit_dc_upper: rdata_next = DC_UPPER_DEF;
      hit_dc_cutoff: rdata_next = DC_CUTOFF_DEF;
      hit_dc_qstop: rdata_next = DC_QSTOP_DEF;
      hit_temp_warn: rdata_next = TEMP_WARN_DEF;
      hit_temp_limit: rdata_next = TEMP_LIMIT_DEF;
      default: rdata_next = 16'h0000;
    endcase
  end

  // Parameter storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_order_reg <= WORD_ORDER_RST;
      scan_wdog_reg <= SCAN_WDOG_RST;
    end else begin
      word_order_reg <= word_order_next;
      scan_wdog_reg <= scan_wdog_next;
    end
  end

  // Access answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= param_req;
      if (rd_cycle) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // User restore strobe to the drive's other persistent values
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      user_pulse_reg <= 1'b0;
    end else begin
      user_pulse_reg <= user_start;
    end
  end

  // ==========================================================
  // Word ordering of 32-bit values
  wire [31:0] tx_ordered = order_words(tx_dword, low_first);
  wire [31:0] rx_ordered = order_words({rx_word_first, rx_word_second},
                                       low_first);

  // Registered link words and received dword
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_first_reg <= 16'h0000;
      tx_second_reg <= 16'h0000;
      rx_dword_reg <= 32'h00000000;
    end else begin
      tx_first_reg <= tx_ordered[31:16];
      tx_second_reg <= tx_ordered[15:0];
      rx_dword_reg <= rx_ordered;
    end
  end

  // ==========================================================
  // DC bus supervision
  wire at_cutoff = (dc_bus_voltage <= DC_CUTOFF_DEF);
  wire at_qstop = (dc_bus_voltage <= DC_QSTOP_DEF);

  // Registered supervision levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_off_reg <= 1'b0;
      quick_stop_reg <= 1'b0;
    end else begin
      drive_off_reg <= at_cutoff;
      quick_stop_reg <= at_qstop;
    end
  end

  // ==========================================================
  // Sub-blocks

  // I/O scan timeout supervision
  dpsgb_scan_watchdog #(
    .MS_CYCLES(MS_CYCLES)
  ) u_watchdog (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wdog_time(scan_wdog_reg),
    .scan_msg(scan_msg),
    .guard_error(guard_error),
    .armed(scan_armed)
  );

  // The user restore never reaches this writer
  dpsgb_nv_writer u_nv_writer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .save_start(save_start),
    .factory_start(factory_start),
    .cur_word_order(word_order_reg),
    .cur_scan_time(scan_wdog_reg),
    .nvm_ack(nvm_ack),
    .nvm_req(nvm_req),
    .nvm_word_order(nvm_word_order),
    .nvm_scan_time(nvm_scan_time),
    .save_busy(save_busy),
    .factory_busy(factory_busy)
  );

  // ==========================================================
  // Outputs
  assign param_ack = ack_reg;
  assign param_rdata = rdata_reg;
  assign tx_word_first = tx_first_reg;
  assign tx_word_second = tx_second_reg;
  assign rx_dword = rx_dword_reg;
  assign drive_off = drive_off_reg;
  assign quick_stop = quick_stop_reg;
  assign user_restore_pulse = user_pulse_reg;

  // ==========================================================
  // Checks
  a_wdog_range_guard: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_wdog && param_wdata > SCAN_WDOG_MAX
    |=> $stable(scan_wdog_reg))
    else $error("watchdog time above 10000 was accepted");
  a_wdog_write_takes: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_wdog && param_wdata <= SCAN_WDOG_MAX
    |=> scan_wdog_reg == $past(param_wdata))
    else $error("watchdog time write lost");
  a_wdog_readback: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_wdog |=> param_rdata == $past(scan_wdog_reg))
    else $error("watchdog time reads wrong");
  a_order_range: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_order && param_wdata > WORD_ORDER_MAX
    |=> $stable(word_order_reg))
    else $error("word order above 1 was accepted");
  a_order_write_takes: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_order && param_wdata <= WORD_ORDER_MAX
    |=> word_order_reg == $past(param_wdata))
    else $error("word order write lost");
  a_word_order_tx: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $stable(word_order_reg) && word_order_reg[ORDER_BIT] == LOW_WORD_FIRST
    |=> tx_word_first == $past(tx_dword[15:0]))
    else $error("low word not sent first");
  a_order_tx_high: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $stable(word_order_reg) && word_order_reg[ORDER_BIT] == HIGH_WORD_FIRST
    |=> tx_word_first == $past(tx_dword[31:16]))
    else $error("high word not sent first");
  a_word_order_hi: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $stable(word_order_reg) && word_order_reg[ORDER_BIT] == HIGH_WORD_FIRST
    |=> rx_dword[31:16] == $past(rx_word_first))
    else $error("high word not taken first");
  a_order_rx_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $stable(word_order_reg) && word_order_reg[ORDER_BIT] == LOW_WORD_FIRST
    |=> rx_dword[31:16] == $past(rx_word_second))
    else $error("low word not taken first");
  a_cutoff_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    dc_bus_voltage <= DC_CUTOFF_DEF |=> drive_off)
    else $error("drive not switched off at cutoff");
  a_cutoff_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    dc_bus_voltage > DC_CUTOFF_DEF |=> !drive_off)
    else $error("drive switched off above cutoff");
  a_qstop_level: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> quick_stop == $past(dc_bus_voltage <= DC_QSTOP_DEF))
    else $error("quick stop does not follow its level");
  a_save_starts: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    save_start && !nvm_req |=> nvm_req ##0 save_busy)
    else $error("save command did not start a memory write");
  a_save_done_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_save && !save_busy |=> param_rdata == 16'h0000)
    else $error("finished save does not read zero");
  a_factory_channel: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_factory && !param_from_commissioning && !nvm_req
    |=> !factory_busy)
    else $error("factory restore from a foreign channel");
  a_factory_zero_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cycle && hit_factory && param_wdata == 16'h0000 && !nvm_req
    |=> !nvm_req)
    else $error("factory restore 0 caused an action");
  a_factory_live_kept: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    factory_start |=> word_order_reg == $past(word_order_reg)
    && scan_wdog_reg == $past(scan_wdog_reg))
    else $error("factory defaults applied before power-on");
  a_user_no_store: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    user_start && !nvm_req |=> !nvm_req ##1 !nvm_req)
    else $error("user restore wrote to memory");
  a_user_pulse_once: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    user_start |=> user_restore_pulse && $stable(word_order_reg))
    else $error("user restore pulse missing or comm value changed");
  a_ro_limits: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_temp_limit |=> $signed(param_rdata) == TEMP_LIMIT_DEF)
    else $error("temperature limit reads wrong");
  a_temp_warn_ro: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_temp_warn |=> $signed(param_rdata) == TEMP_WARN_DEF)
    else $error("temperature warning level reads wrong");
  a_ro_dc_upper: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_dc_upper |=> param_rdata == DC_UPPER_DEF)
    else $error("dc bus upper limit reads wrong");
  a_dc_cutoff_ro: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_dc_cutoff |=> param_rdata == DC_CUTOFF_DEF)
    else $error("dc bus cutoff level reads wrong");
  a_dc_qstop_ro: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rd_cycle && hit_dc_qstop |=> param_rdata == DC_QSTOP_DEF)
    else $error("dc bus quick-stop level reads wrong");

endmodule // dpsgb_param_bank

// >>> rtl/dpsgb_pkg.sv
package dpsgb_pkg;

  // ==========================================================
  // Parameter addresses
  localparam logic [15:0] ADDR_NV_SAVE = 16'h0402;
  localparam logic [15:0] ADDR_FACTORY = 16'h0404;
  localparam logic [15:0] ADDR_USER_RESTORE = 16'h0410;
  localparam logic [15:0] ADDR_DC_UPPER = 16'h1006;
  localparam logic [15:0] ADDR_DC_CUTOFF = 16'h1008;
  localparam logic [15:0] ADDR_TEMP_WARN = 16'h100C;
  localparam logic [15:0] ADDR_TEMP_LIMIT = 16'h100E;
  localparam logic [15:0] ADDR_DC_QSTOP = 16'h1014;
  localparam logic [15:0] ADDR_WORD_ORDER = 16'h190A;
  localparam logic [15:0] ADDR_SCAN_WDOG = 16'h190E;

  // ==========================================================
  // Field positions and command values
  localparam int CMD_BIT = 0;
  localparam int ORDER_BIT = 0;
  localparam logic [15:0] FACTORY_YES = 16'h0001;
  localparam logic [15:0] FACTORY_MAX = 16'h0003;
  localparam logic HIGH_WORD_FIRST = 1'b0;
  localparam logic LOW_WORD_FIRST = 1'b1;
  localparam logic [15:0] WORD_ORDER_MAX = 16'h0001;
  localparam logic [15:0] SCAN_WDOG_MAX = 16'h2710;

  // ==========================================================
  // Reset and default values
  localparam logic [15:0] WORD_ORDER_RST = 16'h0000;
  localparam logic [15:0] SCAN_WDOG_RST = 16'h0000;
  localparam logic [15:0] DC_UPPER_DEF = 16'h0FA0;
  localparam logic [15:0] DC_CUTOFF_DEF = 16'h0190;
  localparam logic [15:0] DC_QSTOP_DEF = 16'h01C2;
  localparam logic signed [15:0] TEMP_WARN_DEF = 16'sh0050;
  localparam logic signed [15:0] TEMP_LIMIT_DEF = 16'sh005A;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_PS = 1000000000;
  localparam int MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;

  // ==========================================================
  // State types
  typedef enum logic [1:0] {
    DPSGB_WD_OFF,
    DPSGB_WD_WAIT,
    DPSGB_WD_ARMED
  } dpsgb_wd_state_t;

  typedef enum logic {
    DPSGB_NV_IDLE,
    DPSGB_NV_WRITE
  } dpsgb_nv_state_t;

endpackage

// >>> rtl/dpsgb_scan_watchdog.sv
`timescale 1ns/100ps
module dpsgb_scan_watchdog #(
  parameter int MS_CYCLES = dpsgb_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] wdog_time,
  input wire logic scan_msg,
  output logic guard_error,
  output logic armed
);
  import dpsgb_pkg::*;

  localparam logic [19:0] PRESCALE_LAST = 20'(MS_CYCLES - 1);

  dpsgb_wd_state_t state_reg, state_next;
  logic [19:0] pre_reg, pre_next;
  logic [15:0] ms_reg, ms_next;
  logic error_reg, error_next;
  wire enabled = (wdog_time != 16'h0000);
  wire ms_tick = (pre_reg == PRESCALE_LAST);
  wire elapsed = ms_tick && ((ms_reg + 16'h0001) >= wdog_time);

  // ==========================================================
  // Arming and timeout sequence
  always_comb begin
    state_next = state_reg;
    pre_next = pre_reg;
    ms_next = ms_reg;
    error_next = 1'b0;
    case (state_reg)
      DPSGB_WD_OFF: begin
        if (enabled) begin
          state_next = DPSGB_WD_WAIT;
        end
      end
      DPSGB_WD_WAIT: begin
        pre_next = 20'h00000;
        ms_next = 16'h0000;
        if (!enabled) begin
          state_next = DPSGB_WD_OFF;
        end else if (scan_msg) begin
          state_next = DPSGB_WD_ARMED;
        end
      end
      DPSGB_WD_ARMED: begin
        if (!enabled) begin
          state_next = DPSGB_WD_OFF;
        end else if (scan_msg) begin
          pre_next = 20'h00000;
          ms_next = 16'h0000;
        end else if (elapsed) begin
          error_next = 1'b1;
          state_next = DPSGB_WD_WAIT;
        end else if (ms_tick) begin
          pre_next = 20'h00000;
          ms_next = ms_reg + 16'h0001;
        end else begin
          pre_next = pre_reg + 20'h00001;
        end
      end
      default: begin
        state_next = DPSGB_WD_OFF;
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DPSGB_WD_OFF;
      pre_reg <= 20'h00000;
      ms_reg <= 16'h0000;
      error_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
      error_reg <= error_next;
    end
  end

  assign guard_error = error_reg;
  assign armed = (state_reg == DPSGB_WD_ARMED);

  // ==========================================================
  // Checks
  a_error_needs_arm: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    guard_error |-> $past(state_reg) == DPSGB_WD_ARMED)
    else $error("guard error without armed supervision");
  a_wait_arms: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == DPSGB_WD_WAIT && enabled && scan_msg |=> armed)
    else $error("first scan message did not arm supervision");
  a_error_disarms: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    guard_error |-> !armed)
    else $error("supervision still armed after guard error");
  a_zero_disables: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !enabled |=> !armed && !guard_error)
    else $error("zero watchdog time did not disable supervision");

endmodule // dpsgb_scan_watchdog

// >>> rtl/dpsgb_nv_writer.sv
`timescale 1ns/100ps
module dpsgb_nv_writer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic save_start,
  input wire logic factory_start,
  input wire logic [15:0] cur_word_order,
  input wire logic [15:0] cur_scan_time,
  input wire logic nvm_ack,
  output logic nvm_req,
  output logic [15:0] nvm_word_order,
  output logic [15:0] nvm_scan_time,
  output logic save_busy,
  output logic factory_busy
);
  import dpsgb_pkg::*;

  dpsgb_nv_state_t state_reg;
  logic kind_reg;
  logic [15:0] order_reg;
  logic [15:0] scan_reg;
  wire idle = (state_reg == DPSGB_NV_IDLE);
  wire start = idle && (save_start || factory_start);

  // ==========================================================
  // Image capture and write request, held until the memory acks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DPSGB_NV_IDLE;
      kind_reg <= 1'b0;
      order_reg <= WORD_ORDER_RST;
      scan_reg <= SCAN_WDOG_RST;
    end else begin
      case (state_reg)
        DPSGB_NV_IDLE: begin
          if (start) begin
            state_reg <= DPSGB_NV_WRITE;
            kind_reg <= factory_start;
            order_reg <= factory_start ? WORD_ORDER_RST : cur_word_order;
            scan_reg <= factory_start ? SCAN_WDOG_RST : cur_scan_time;
          end
        end
        DPSGB_NV_WRITE: begin
          if (nvm_ack) begin
            state_reg <= DPSGB_NV_IDLE;
          end
        end
        default: begin
          state_reg <= DPSGB_NV_IDLE;
        end
      endcase
    end
  end

  assign nvm_req = !idle;
  assign nvm_word_order = order_reg;
  assign nvm_scan_time = scan_reg;
  assign save_busy = !idle && !kind_reg;
  assign factory_busy = !idle && kind_reg;

  // ==========================================================
  // Checks
  a_req_holds: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    nvm_req && !nvm_ack |=> nvm_req)
    else $error("memory request dropped before ack");

endmodule // dpsgb_nv_writer

// >>> sim/dpsgb_nvm_model.sv
`timescale 1ns/100ps
// ==========================================================
// Nonvolatile memory responder
module dpsgb_nvm_model (
  input wire logic ref_clk,
  input wire logic nvm_req,
  input wire logic [3:0] delay,
  output logic nvm_ack
);
  logic [3:0] cnt;
  initial begin
    nvm_ack = 1'b0;
    cnt = 4'h0;
  end
  // Pulses ack once a pending store has waited delay cycles
  always @(negedge ref_clk) begin
    if (nvm_req && !nvm_ack && cnt >= delay) begin
      nvm_ack <= 1'b1;
      cnt <= 4'h0;
    end else begin
      nvm_ack <= 1'b0;
      cnt <= (nvm_req && !nvm_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // dpsgb_nvm_model

// >>> sim/test_drive_param_scan_guard_bank.sv
`timescale 1ns/100ps
module test_drive_param_scan_guard_bank;
  import dpsgb_pkg::*;
  logic clk, rst_n, req, wr, comm, ack, scan, gerr, armed, doff, qs;
  logic upulse, nreq, nack, nprev;
  logic [15:0] addr, wdata, rdata, tw1, tw2, rw1, rw2, vbus, nwo, nst;
  logic [31:0] txd, rxd;
  logic [3:0] dly;
  int mismatches, cmp_count, nvs, gcnt, n;
  logic [15:0] ro_a [5] = '{ADDR_DC_UPPER, ADDR_DC_CUTOFF, ADDR_TEMP_WARN,
    ADDR_TEMP_LIMIT, ADDR_DC_QSTOP};
  logic [15:0] ro_v [5] = '{DC_UPPER_DEF, DC_CUTOFF_DEF, TEMP_WARN_DEF,
    TEMP_LIMIT_DEF, DC_QSTOP_DEF};

  dpsgb_param_bank #(.MS_CYCLES(4)) dpsgb_param_bank_i (
    .ref_clk(clk), .rst_n(rst_n), .param_req(req), .param_wr(wr),
    .param_addr(addr), .param_wdata(wdata),
    .param_from_commissioning(comm), .param_ack(ack),
    .param_rdata(rdata), .scan_msg(scan), .guard_error(gerr),
    .scan_armed(armed), .tx_dword(txd), .tx_word_first(tw1),
    .tx_word_second(tw2), .rx_word_first(rw1), .rx_word_second(rw2),
    .rx_dword(rxd), .dc_bus_voltage(vbus), .drive_off(doff),
    .quick_stop(qs), .user_restore_pulse(upulse), .nvm_req(nreq),
    .nvm_ack(nack), .nvm_word_order(nwo), .nvm_scan_time(nst));
  dpsgb_nvm_model dpsgb_nvm_model_i (
    .ref_clk(clk), .nvm_req(nreq), .delay(dly), .nvm_ack(nack));

  // ==========================================================
  // Clock, event counters and helper tasks
  always #2 clk = ~clk;
  // Counts memory store starts and guard errors
  always @(posedge clk) begin
    nprev <= nreq;
    if (nreq === 1'b1 && nprev !== 1'b1) nvs++;
    if (gerr === 1'b1) gcnt++;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d,
           input logic c);
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    comm = c;
    @(negedge clk);
    req = 1'b0;
    chk(ack, 1);
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000, 1'b0);
    chk(rdata, exp);
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task scn;
    @(negedge clk);
    scan = 1'b1;
    @(negedge clk);
    scan = 1'b0;
  endtask
  task wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog against a hung run
  initial begin
    #20000;
    mismatches++;
    wrap_up;
  end

  // ==========================================================
  // Test sequence
  initial begin
    clk = 0;
    rst_n = 0;
    req = 0;
    wr = 0;
    comm = 0;
    scan = 0;
    addr = 0;
    wdata = 0;
    txd = 0;
    rw1 = 0;
    rw2 = 0;
    vbus = 16'h0FA0;
    dly = 4'h6;
    cyc(3);
    rst_n = 1;
    rd(ADDR_WORD_ORDER, 16'h0000);
    rd(16'h1234, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ro_a[i], 16'h5A5A, 1'b0);
      rd(ro_a[i], ro_v[i]);
    end
    // Scan watchdog
    acc(1'b1, ADDR_SCAN_WDOG, 16'h2711, 1'b0);
    rd(ADDR_SCAN_WDOG, 16'h0000);
    acc(1'b1, ADDR_SCAN_WDOG, 16'h0002, 1'b0);
    rd(ADDR_SCAN_WDOG, 16'h0002);
    cyc(12);
    chk({armed, gcnt[0]}, 0);
    scn;
    cyc(1);
    chk(armed, 1);
    repeat (4) begin
      cyc(5);
      scn;
    end
    chk(gcnt, 0);
    n = 0;
    while (gerr !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(n >= 5 && n <= 11, 1);
    chk(armed, 0);
    cyc(12);
    chk(gcnt, 1);
    scn;
    cyc(1);
    chk(armed, 1);
    acc(1'b1, ADDR_SCAN_WDOG, 16'h0000, 1'b0);
    cyc(1);
    chk(armed, 0);
    acc(1'b1, ADDR_SCAN_WDOG, 16'h0005, 1'b0);
    // Word order
    txd = 32'h1234ABCD;
    rw1 = 16'h1111;
    rw2 = 16'h2222;
    for (int o = 0; o < 2; o++) begin
      acc(1'b1, ADDR_WORD_ORDER, o[15:0], 1'b0);
      cyc(2);
      chk({tw1, tw2}, o ? 32'hABCD1234 : 32'h1234ABCD);
      chk(rxd, o ? 32'h22221111 : 32'h11112222);
    end
    acc(1'b1, ADDR_WORD_ORDER, 16'h0002, 1'b0);
    rd(ADDR_WORD_ORDER, 16'h0001);
    // Bus voltage thresholds
    vbus = DC_CUTOFF_DEF;
    cyc(2);
    chk({doff, qs}, 2'b11);
    vbus = DC_CUTOFF_DEF + 16'h0001;
    cyc(2);
    chk({doff, qs}, 2'b01);
    vbus = DC_QSTOP_DEF + 16'h0001;
    cyc(2);
    chk({doff, qs}, 2'b00);
    // Save, polled until it reads zero
    acc(1'b1, ADDR_NV_SAVE, 16'h0001, 1'b0);
    chk(nreq, 1);
    chk({nwo, nst}, {16'h0001, 16'h0005});
    rd(ADDR_NV_SAVE, 16'h0001);
    n = 0;
    do begin
      acc(1'b0, ADDR_NV_SAVE, 16'h0000, 1'b0);
      n++;
    end while (rdata !== 16'h0000 && n < 20);
    chk({nreq, rdata}, 0);
    // Factory restore
    dly = 4'h3;
    acc(1'b1, ADDR_FACTORY, 16'h0001, 1'b0);
    acc(1'b1, ADDR_FACTORY, 16'h0000, 1'b1);
    cyc(3);
    chk(nvs, 1);
    acc(1'b1, ADDR_FACTORY, 16'h0001, 1'b1);
    chk(nreq, 1);
    chk({nwo, nst}, 32'h00000000);
    rd(ADDR_FACTORY, 16'h0001);
    cyc(4);
    chk(nvs, 2);
    rd(ADDR_FACTORY, 16'h0000);
    rd(ADDR_WORD_ORDER, 16'h0001);
    // User restore
    acc(1'b1, ADDR_USER_RESTORE, 16'h0001, 1'b0);
    chk(upulse, 1);
    cyc(4);
    chk(nvs, 2);
    rd(ADDR_SCAN_WDOG, 16'h0005);
    wrap_up;
  end
endmodule // test_drive_param_scan_guard_bank
